// >>> rtc_pkg.sv
package rtc_pkg;
  // register offsets on the plain port (page 0 / page 1 share 1..6)
  localparam logic [3:0] OFS_SEC = 4'h0;
  localparam logic [3:0] OFS_MIN = 4'h1;
  localparam logic [3:0] OFS_HOUR = 4'h2;
  localparam logic [3:0] OFS_WDAY = 4'h3;
  localparam logic [3:0] OFS_DATE = 4'h4;
  localparam logic [3:0] OFS_MONTH = 4'h5;
  localparam logic [3:0] OFS_YEAR = 4'h6;
  localparam logic [3:0] OFS_PAGE = 4'h7;
  localparam logic [3:0] OFS_RESET = 4'h8;
  // page_control_reg bit positions
  localparam int B_IRQ_EN = 7;
  localparam int B_ADJ = 4;
  localparam int B_RUN = 3;
  localparam int B_AL_EN = 2;
  localparam int B_PAGE = 0;
  // counter_reset_reg bit positions
  localparam int B_M1 = 7;
  localparam int B_M16 = 6;
  localparam int B_CLR = 5;
  localparam int B_PRESET = 4;
  localparam int B_M2 = 2;
  localparam int B_M4 = 1;
  localparam int B_M8 = 0;
  // number of selectable periodic rates (1,2,4,8,16 Hz)
  localparam int N_RATE = 5;
  localparam logic [N_RATE-1:0] MASK_RST = 5'h1F;
  // second counter width for the 32.768 kHz divider
  localparam int CNT_W = 15;
  // bcd limits and preset values
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_HALF = 8'h30;
  localparam logic [7:0] BCD_MAX_SEC = 8'h59;
  localparam logic [7:0] BCD_MAX_HOUR = 8'h23;
  localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
  localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
  localparam logic [7:0] BCD_FEB = 8'h02;
  localparam logic [7:0] BCD_APR = 8'h04;
  localparam logic [7:0] BCD_JUN = 8'h06;
  localparam logic [7:0] BCD_SEP = 8'h09;
  localparam logic [7:0] BCD_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [2:0] WDAY_SUN = 3'h0;
  localparam logic [2:0] WDAY_SAT = 3'h6;
  localparam logic [2:0] WDAY_ANY = 3'h7;
  localparam logic [5:0] DATE_ANY = 6'h3F;
  localparam logic [1:0] LEAP_YES = 2'h0;
endpackage

// >>> rtc_fs_sync.sv
`timescale 1ns/100ps
// brings the low-speed clock pin into mclk and gives one pulse per rising edge
module rtc_fs_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic fs_i,
  output logic tick_o
);
  // synchroniser stages, accepted level and tick in one state word
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic tick;
  } rtc_sync_s;
  rtc_sync_s st_reg;
  rtc_sync_s st_next;

  // a change counts only once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = fs_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.tick = 1'b0;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
      st_next.tick = st_reg.s3 & ~st_reg.lvl;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule

// >>> rtc_core.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - alarm drives irq only when fully selected
// - single cleared mask selects its periodic rate while alarm enable is low
// - second counter divides low-speed clock to 1 Hz
// - 1 Hz irq coincides with second count-up
// - after counter reset, next tick one second later
// - run enable low stops calendar, divider keeps counting
// - page bit maps alarm registers into window
// - interrupt signals event with falling edge
// - alarm fires when minute, hour, day, weekday match
// - alarm preset loads 00:00, day 01, Sunday
// - alarm writes take effect on low-speed clock
// - second adjust sampled at count-up, rounds
// - counter clear pending bit reads back status
module rtc_core #(
  parameter int SEC_DIV = 32768 // low-speed ticks per second, power of two
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic fs_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic calendar_irq_n_o
);
  import rtc_pkg::*;

  // the whole state of the block
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // second counter
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [1:0] leap;
    logic [7:0] pa_min; // alarm as written by software
    logic [7:0] pa_hour;
    logic [5:0] pa_date;
    logic [2:0] pa_wday;
    logic [7:0] aa_min; // alarm as used by the comparator
    logic [7:0] aa_hour;
    logic [5:0] aa_date;
    logic [2:0] aa_wday;
    logic irq_enable;
    logic adjust;
    logic clock_run_enable;
    logic alarm_enable;
    logic page;
    logic [N_RATE-1:0] rate_mask; // bit 0 = 1 Hz .. bit 4 = 16 Hz
    logic second_counter_clear;
    logic match_d;
    logic irq_n;
    logic [7:0] rdata;
  } rtc_state_s;

  rtc_state_s st_reg;
  rtc_state_s st_next;
  logic fs_tick; // one mclk pulse per low-speed clock rising edge

  // low-speed clock pin synchroniser
  rtc_fs_sync u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .fs_i(fs_i),
    .tick_o(fs_tick)
  );

  // next bcd value, two digits
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v + 8'h01;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  // last day of a month, bcd
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [1:0] lp);
    logic [7:0] r;
    r = DAYS_31;
    if (m == BCD_FEB) begin
      r = (lp == LEAP_YES) ? DAYS_29 : DAYS_28;
    end else if (m == BCD_APR || m == BCD_JUN || m == BCD_SEP || m == BCD_NOV) begin
      r = DAYS_30;
    end
    return r;
  endfunction

  // combinational helpers
  logic wrap;
  logic sec_tick;
  logic [N_RATE-1:0] rate_tick;
  logic sel_alarm;
  logic rate_hit;
  logic match;
  logic alarm_evt;
  logic evt;

  // rate k ticks when the low bits of the divider wrap at SEC_DIV >> k
  for (genvar k = 0; k < N_RATE; k++) begin : g_rate
    localparam logic [CNT_W-1:0] PM = CNT_W'((SEC_DIV >> k) - 1);
    assign rate_tick[k] = fs_tick && !st_reg.second_counter_clear
                          && ((st_reg.cnt & PM) == PM);
  end

  // selection, alarm compare and event decision
  always_comb begin
    wrap = fs_tick && (st_reg.cnt == CNT_W'(SEC_DIV - 1));
    sec_tick = wrap && !st_reg.second_counter_clear;
    // alarm only with all masks set and alarm enabled; with alarm disabled, one cleared mask
    sel_alarm = (st_reg.rate_mask == MASK_RST) && st_reg.alarm_enable;
    rate_hit = 1'b0;
    if (!st_reg.alarm_enable) begin
      for (int k = 0; k < N_RATE; k++) begin
        if (st_reg.rate_mask == ~(N_RATE'(1) << k)) begin
          rate_hit = rate_tick[k];
        end
      end
    end
    // page-0 time against the active alarm copy, with don't-care codes
    match = (st_reg.min == st_reg.aa_min) && (st_reg.hour == st_reg.aa_hour)
            && (st_reg.aa_date == DATE_ANY || st_reg.date[5:0] == st_reg.aa_date)
            && (st_reg.aa_wday == WDAY_ANY || st_reg.wday == st_reg.aa_wday);
    alarm_evt = match && !st_reg.match_d;
    evt = st_reg.irq_enable && (sel_alarm ? alarm_evt : rate_hit);
  end

  // next state: divider, calendar, control, bus
  always_comb begin
    logic carry;
    carry = 1'b0;
    st_next = st_reg;
    // divider keeps counting whether or not the clock runs
    if (fs_tick) begin
      if (st_reg.second_counter_clear) begin
        st_next.cnt = '0;
        st_next.second_counter_clear = 1'b0;
      end else if (wrap) begin
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
      // alarm settings reach the comparator on the low-speed clock
      st_next.aa_min = st_reg.pa_min;
      st_next.aa_hour = st_reg.pa_hour;
      st_next.aa_date = st_reg.pa_date;
      st_next.aa_wday = st_reg.pa_wday;
    end
    // count-up of the time, suppressed with carries when stopped
    if (sec_tick) begin
      st_next.adjust = 1'b0;
      if (st_reg.clock_run_enable) begin
        if (st_reg.adjust) begin
          st_next.sec = BCD_ZERO;
          carry = (st_reg.sec >= BCD_HALF);
        end else begin
          carry = (st_reg.sec == BCD_MAX_SEC);
          st_next.sec = carry ? BCD_ZERO : bcd_inc(st_reg.sec);
        end
        if (carry) begin
          carry = (st_reg.min == BCD_MAX_SEC);
          st_next.min = carry ? BCD_ZERO : bcd_inc(st_reg.min);
        end
        if (carry) begin
          carry = (st_reg.hour == BCD_MAX_HOUR);
          st_next.hour = carry ? BCD_ZERO : bcd_inc(st_reg.hour);
        end
        if (carry) begin
          st_next.wday = (st_reg.wday == WDAY_SAT) ? WDAY_SUN : st_reg.wday + 3'h1;
          carry = (st_reg.date == last_day(st_reg.month, st_reg.leap));
          st_next.date = carry ? BCD_ONE : bcd_inc(st_reg.date);
        end
        if (carry) begin
          carry = (st_reg.month == BCD_MAX_MONTH);
          st_next.month = carry ? BCD_ONE : bcd_inc(st_reg.month);
        end
        if (carry) begin
          st_next.year = (st_reg.year == BCD_MAX_YEAR) ? BCD_ZERO : bcd_inc(st_reg.year);
          st_next.leap = st_reg.leap + 2'h1;
        end
      end
    end
    // edge memory of the alarm compare
    st_next.match_d = match;
    // interrupt: drop on event, rise at the next low-speed rising edge
    if (evt) begin
      st_next.irq_n = 1'b0;
    end else if (fs_tick) begin
      st_next.irq_n = 1'b1;
    end
    // writes come last so a set by software wins over a hardware clear
    if (wr_i) begin
      if (addr_i == OFS_SEC) begin
        st_next.sec = wdata_i;
      end else if (addr_i == OFS_MIN) begin
        if (st_reg.page) st_next.pa_min = wdata_i;
        else st_next.min = wdata_i;
      end else if (addr_i == OFS_HOUR) begin
        if (st_reg.page) st_next.pa_hour = wdata_i;
        else st_next.hour = wdata_i;
      end else if (addr_i == OFS_WDAY) begin
        if (st_reg.page) st_next.pa_wday = wdata_i[2:0];
        else st_next.wday = wdata_i[2:0];
      end else if (addr_i == OFS_DATE) begin
        if (st_reg.page) st_next.pa_date = wdata_i[5:0];
        else st_next.date = {2'h0, wdata_i[5:0]};
      end else if (addr_i == OFS_MONTH) begin
        if (!st_reg.page) st_next.month = {3'h0, wdata_i[4:0]};
      end else if (addr_i == OFS_YEAR) begin
        if (st_reg.page) st_next.leap = wdata_i[1:0];
        else st_next.year = wdata_i;
      end else if (addr_i == OFS_PAGE) begin
        st_next.irq_enable = wdata_i[B_IRQ_EN];
        st_next.clock_run_enable = wdata_i[B_RUN];
        st_next.alarm_enable = wdata_i[B_AL_EN];
        st_next.page = wdata_i[B_PAGE];
        if (wdata_i[B_ADJ]) st_next.adjust = 1'b1;
      end else if (addr_i == OFS_RESET) begin
        // whole-value write: masks take the written bits directly
        st_next.rate_mask = {wdata_i[B_M16], wdata_i[B_M8], wdata_i[B_M4],
                             wdata_i[B_M2], wdata_i[B_M1]};
        if (wdata_i[B_CLR]) st_next.second_counter_clear = 1'b1;
        if (wdata_i[B_PRESET]) begin
          st_next.pa_min = BCD_ZERO;
          st_next.pa_hour = BCD_ZERO;
          st_next.pa_date = BCD_ONE[5:0];
          st_next.pa_wday = WDAY_SUN;
        end
      end
    end
    // read data stands in the cycle after the strobe only
    st_next.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == OFS_SEC) begin
        st_next.rdata = st_reg.sec;
      end else if (addr_i == OFS_MIN) begin
        st_next.rdata = st_reg.page ? st_reg.pa_min : st_reg.min;
      end else if (addr_i == OFS_HOUR) begin
        st_next.rdata = st_reg.page ? st_reg.pa_hour : st_reg.hour;
      end else if (addr_i == OFS_WDAY) begin
        st_next.rdata = {5'h00, st_reg.page ? st_reg.pa_wday : st_reg.wday};
      end else if (addr_i == OFS_DATE) begin
        st_next.rdata = st_reg.page ? {2'h0, st_reg.pa_date} : st_reg.date;
      end else if (addr_i == OFS_MONTH) begin
        st_next.rdata = st_reg.page ? 8'h00 : st_reg.month;
      end else if (addr_i == OFS_YEAR) begin
        st_next.rdata = st_reg.page ? {6'h00, st_reg.leap} : st_reg.year;
      end else if (addr_i == OFS_PAGE) begin
        st_next.rdata[B_IRQ_EN] = st_reg.irq_enable;
        st_next.rdata[B_ADJ] = st_reg.adjust;
        st_next.rdata[B_RUN] = st_reg.clock_run_enable;
        st_next.rdata[B_AL_EN] = st_reg.alarm_enable;
        st_next.rdata[B_PAGE] = st_reg.page;
      end else if (addr_i == OFS_RESET) begin
        st_next.rdata[B_M1] = st_reg.rate_mask[0];
        st_next.rdata[B_M2] = st_reg.rate_mask[1];
        st_next.rdata[B_M4] = st_reg.rate_mask[2];
        st_next.rdata[B_M8] = st_reg.rate_mask[3];
        st_next.rdata[B_M16] = st_reg.rate_mask[4];
        st_next.rdata[B_CLR] = st_reg.second_counter_clear;
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.rate_mask <= MASK_RST;
      st_reg.irq_n <= 1'b1;
      st_reg.month <= BCD_ONE;
      st_reg.date <= BCD_ONE;
      st_reg.pa_date <= BCD_ONE[5:0];
      st_reg.aa_date <= BCD_ONE[5:0];
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign calendar_irq_n_o = st_reg.irq_n;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_one_hz_sync: assert property (ce_i && sec_tick && st_reg.irq_enable && !st_reg.alarm_enable
    && st_reg.rate_mask == 5'h1E |=> !calendar_irq_n_o) else $error("1 Hz tick gave no irq");
  a_fall_cause: assert property ($fell(calendar_irq_n_o) |-> $past(st_reg.irq_enable))
    else $error("irq fell while disabled");
  a_low_hold: assert property ($rose(calendar_irq_n_o) |-> $past(fs_tick && ce_i))
    else $error("irq released off a low-speed edge");
  a_adjust_done: assert property (ce_i && sec_tick && st_reg.adjust && st_reg.clock_run_enable
    && !wr_i |=> !st_reg.adjust && st_reg.sec == BCD_ZERO) else $error("adjust not applied");
  a_clear_done: assert property (ce_i && fs_tick && st_reg.second_counter_clear && !wr_i
    |=> !st_reg.second_counter_clear && st_reg.cnt == '0) else $error("counter clear not applied");
  a_clock_stop: assert property (ce_i && !st_reg.clock_run_enable && !wr_i
    |=> $stable(st_reg.sec) && $stable(st_reg.min)) else $error("time moved while stopped");
  a_preset_vals: assert property (ce_i && wr_i && addr_i == OFS_RESET && wdata_i[B_PRESET]
    |=> st_reg.pa_min == BCD_ZERO && st_reg.pa_wday == WDAY_SUN && st_reg.pa_date == 6'h01)
    else $error("alarm preset wrong");
  a_alarm_sync: assert property (!$stable(st_reg.aa_min) |-> $past(fs_tick))
    else $error("alarm took effect off a low-speed edge");
  a_sec_step: assert property (ce_i && sec_tick && st_reg.clock_run_enable && !st_reg.adjust
    && !wr_i |=> st_reg.sec != $past(st_reg.sec)) else $error("second did not advance");
endmodule

// >>> test_rtc_alarm_periodic_interrupt.sv
`timescale 1ns/100ps
// self-checking bench for the calendar interrupt, rate selection and alarm logic
module test_rtc_alarm_periodic_interrupt;
  import rtc_pkg::*;
  localparam int SEC_DIV = 32; // shortened second: 32 low-speed ticks
  localparam int FS_HALF = 100; // low-speed half period in ns (fast stand-in)
  localparam int LIMIT = 30000; // cycle ceiling for the whole run
  logic mclk_i;
  logic rst_n_i;
  logic ce_i;
  logic fs_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic calendar_irq_n_o;
  int n_errors = 0; // mismatches seen
  int check_count = 0; // comparisons made
  int n_fall = 0; // falling edges of the interrupt
  int cyc = 0; // cycle counter for the hang guard
  time t_fall = 0; // time of the last interrupt fall
  logic [7:0] rmask[8]; // rate selection table: mask register values
  logic [7:0] rpage[8]; // matching page register values
  int rexp[8]; // expected events per second
  logic [7:0] adj_sec[2]; // seconds before adjust
  logic [7:0] adj_min[2]; // minutes expected after adjust
  int i;
  int cnt;
  int k;

  rtc_core #(.SEC_DIV(SEC_DIV)) dut_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .fs_i(fs_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .calendar_irq_n_o(calendar_irq_n_o)
  );

  // system clock, 100 MHz
  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  // low-speed clock, offset so its edges never meet the system clock edge
  initial begin
    fs_i = 1'b0;
    #3;
    forever #(FS_HALF) fs_i = ~fs_i;
  end

  // one comparison, reported at once on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read; data looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // bounded wait for the next interrupt fall
  task automatic wait_fall(input int lim);
    int k0;
    int n;
    k0 = n_fall;
    n = 0;
    while (n_fall == k0 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk({7'h00, n_fall != k0}, 8'h01);
    repeat (3) @(posedge mclk_i);
  endtask

  // count interrupt falls and check each low phase lasts a low-speed period
  always @(negedge calendar_irq_n_o) begin
    n_fall++;
    t_fall = $time;
  end
  always @(posedge calendar_irq_n_o) begin
    if (rst_n_i === 1'b1 && t_fall > 0) begin
      chk({7'h00, ($time - t_fall) >= 2 * FS_HALF - 10}, 8'h01);
    end
  end

  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    // rate table: one cleared mask each, then two cleared masks, alarm enabled, interrupt disabled
    rmask[0] = 8'hC7 & ~(8'h01 << B_M1); rpage[0] = 8'h80; rexp[0] = 1;
    rmask[1] = 8'hC7 & ~(8'h01 << B_M2); rpage[1] = 8'h80; rexp[1] = 2;
    rmask[2] = 8'hC7 & ~(8'h01 << B_M4); rpage[2] = 8'h80; rexp[2] = 4;
    rmask[3] = 8'hC7 & ~(8'h01 << B_M8); rpage[3] = 8'h80; rexp[3] = 8;
    rmask[4] = 8'hC7 & ~(8'h01 << B_M16); rpage[4] = 8'h80; rexp[4] = 16;
    rmask[5] = 8'h46; rpage[5] = 8'h80; rexp[5] = 0;
    rmask[6] = 8'h47; rpage[6] = 8'h84; rexp[6] = 0;
    rmask[7] = 8'h47; rpage[7] = 8'h00; rexp[7] = 0;
    adj_sec[0] = 8'h25; adj_min[0] = 8'h05;
    adj_sec[1] = 8'h45; adj_min[1] = 8'h06;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // reset values and quiet interrupt
    chk({7'h00, calendar_irq_n_o}, 8'h01);
    rd_chk(OFS_PAGE, 8'h00);
    rd_chk(OFS_RESET, 8'hC7);
    rd_chk(OFS_SEC, 8'h00);
    rd_chk(OFS_DATE, 8'h01);
    rd_chk(OFS_MONTH, 8'h01);
    // unmapped index reads zero, writes vanish
    wr(4'h9, 8'hAA);
    rd_chk(4'h9, 8'h00);
    // strobes are ignored while the clock enable is low
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(OFS_SEC, 8'h33);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rd_chk(OFS_SEC, 8'h00);
    // periodic rates: count falls over exactly one second of low-speed ticks
    for (i = 0; i < 8; i++) begin
      wr(OFS_PAGE, 8'h00);
      wr(OFS_RESET, rmask[i]);
      wr(OFS_PAGE, rpage[i] & 8'h7F);
      wr(OFS_PAGE, rpage[i]);
      repeat (2) @(posedge fs_i);
      k = n_fall;
      repeat (SEC_DIV) @(posedge fs_i);
      chk(8'(n_fall - k), 8'(rexp[i]));
    end
    // stopped calendar still sees the 1 Hz interrupt, seconds frozen
    wr(OFS_PAGE, 8'h00);
    wr(OFS_RESET, 8'h47);
    wr(OFS_SEC, 8'h10);
    wr(OFS_PAGE, 8'h80);
    wait_fall(1000);
    wait_fall(1000);
    rd_chk(OFS_SEC, 8'h10);
    rd_chk(OFS_SEC, 8'h10);
    // running calendar: one second per interrupt
    wr(OFS_PAGE, 8'h00);
    wr(OFS_PAGE, 8'h08);
    wr(OFS_PAGE, 8'h88);
    wait_fall(1000);
    wr(OFS_SEC, 8'h20);
    wait_fall(1000);
    rd_chk(OFS_SEC, 8'h21);
    // second adjust, below and above the half minute
    for (i = 0; i < 2; i++) begin
      wait_fall(1000);
      wr(OFS_SEC, adj_sec[i]);
      wr(OFS_MIN, 8'h05);
      wr(OFS_PAGE, 8'h98);
      rd_chk(OFS_PAGE, 8'h98);
      wait_fall(1000);
      rd_chk(OFS_SEC, 8'h00);
      rd_chk(OFS_MIN, adj_min[i]);
      rd_chk(OFS_PAGE, 8'h88);
    end
    // second counter clear: pending bit, then a full second to the next tick
    wait_fall(1000);
    wr(OFS_RESET, 8'h67);
    rd_chk(OFS_RESET, 8'h67);
    cnt = 0;
    k = n_fall;
    while (n_fall == k && cnt < 40) begin
      @(posedge fs_i);
      cnt++;
    end
    chk({7'h00, cnt >= SEC_DIV + 1 && cnt <= SEC_DIV + 3}, 8'h01);
    rd_chk(OFS_RESET, 8'h47);
    // alarm: preset, program on page 1, match at minute 01
    wr(OFS_PAGE, 8'h08);
    wr(OFS_PAGE, 8'h00);
    wr(OFS_RESET, 8'hC7);
    wr(OFS_SEC, 8'h58);
    wr(OFS_MIN, 8'h00);
    wr(OFS_HOUR, 8'h00);
    wr(OFS_YEAR, 8'h24);
    rd_chk(OFS_YEAR, 8'h24);
    wr(OFS_PAGE, 8'h09);
    // page 1: month reads zero, year index holds the leap counter
    rd_chk(OFS_MONTH, 8'h00);
    wr(OFS_YEAR, 8'h02);
    rd_chk(OFS_YEAR, 8'h02);
    wr(OFS_RESET, 8'hD7);
    rd_chk(OFS_MIN, 8'h00);
    rd_chk(OFS_HOUR, 8'h00);
    rd_chk(OFS_WDAY, 8'h00);
    rd_chk(OFS_DATE, 8'h01);
    rd_chk(OFS_RESET, 8'hC7);
    wr(OFS_MIN, 8'h01);
    wr(OFS_WDAY, 8'h07);
    wr(OFS_DATE, 8'h3F);
    rd_chk(OFS_MIN, 8'h01);
    rd_chk(OFS_WDAY, 8'h07);
    rd_chk(OFS_DATE, 8'h3F);
    wr(OFS_PAGE, 8'h0D);
    wr(OFS_PAGE, 8'h8D);
    wait_fall(2000);
    // next alarm written from the handler, read back on page 1
    wr(OFS_MIN, 8'h02);
    rd_chk(OFS_MIN, 8'h02);
    wr(OFS_PAGE, 8'h8C);
    rd_chk(OFS_MIN, 8'h01);
    rd_chk(OFS_SEC, 8'h00);
    // the page-1 leap write must not have touched the page-0 year
    rd_chk(OFS_YEAR, 8'h24);
    close_out();
  end
endmodule
